// *** licb_defines.vh ***
`ifndef LICB_DEFINES_VH
`define LICB_DEFINES_VH

// ==========================================================
// Clock and timing
`define LICB_CLK_PERIOD_NS      20
`define LICB_ONES_PERIOD_NS     488
`define LICB_ONES_CYCLES        (`LICB_ONES_PERIOD_NS / `LICB_CLK_PERIOD_NS)
`define LICB_ONES_CNT_W         5

// ==========================================================
// Register indexes, byte address is index times four
`define LICB_IDX_MONITOR        6'h0b
`define LICB_IDX_DIG_LOOP       6'h0c
`define LICB_IDX_CRITERIA       6'h0d
`define LICB_IDX_ALL_ONES       6'h0e
`define LICB_IDX_GLOBAL         6'h0f
`define LICB_IDX_POINTER        6'h10
`define LICB_IDX_REM_LOOP       6'h17
`define LICB_IDX_CH_ALARM       6'h18
`define LICB_IDX_CH_PROT        6'h19
`define LICB_IDX_CH_CODING      6'h1a
`define LICB_IDX_CH_DEPTH       6'h1b
`define LICB_IDX_CH_POS         6'h1c
`define LICB_IDX_CH_ENABLE      6'h1d
`define LICB_IDX_STATUS         6'h1e

// ==========================================================
// Reset values and writable masks
`define LICB_RESET_VALUE        8'h00
`define LICB_MONITOR_MASK       8'h0f
`define LICB_GLOBAL_MASK        8'hfb
`define LICB_POINTER_MASK       8'h07

// ==========================================================
// Global configuration fields
`define LICB_GLB_RX_INTERNAL    7
`define LICB_GLB_ALARM_ON_LOSS  6
`define LICB_GLB_PROT_DISABLE   5
`define LICB_GLB_AMI            4
`define LICB_GLB_DEPTH_128      3
`define LICB_GLB_POSITION_RX    1
`define LICB_GLB_ATTEN_ENABLE   0

// ==========================================================
// Receive trim codes
`define LICB_TRIM_NONE          3'h0
`define LICB_TRIM_75            3'h1
`define LICB_TRIM_100           3'h2
`define LICB_TRIM_110           3'h3
`define LICB_TRIM_120           3'h4

`endif

// *** licb_mon_decode.v ***
`timescale 1ns/1ns
`include "licb_defines.vh"

module licb_mon_decode (
	input  wire       clk,
	input  wire       arst_n,
	input  wire [3:0] select,
	output reg        mon_enable,
	output reg        mon_transmit,
	output reg  [7:0] mon_line
);

	// ==========================================================
	// Code to one-hot line, zero code means no monitoring
	function [7:0] line_hot;
		input [2:0] code;
		begin
			line_hot = 8'h00;
			if (code != 3'h0) begin
				line_hot[code] = 1'b1;
			end
		end
	endfunction

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mon_enable   <= 1'b0;
			mon_transmit <= 1'b0;
			mon_line     <= 8'h00;
		end else begin
			mon_enable   <= (select[2:0] != 3'h0);
			mon_transmit <= select[3] & (select[2:0] != 3'h0);
			mon_line     <= line_hot(select[2:0]);
		end
	end

endmodule // licb_mon_decode

// *** licb_chan_path.v ***
`timescale 1ns/1ns

module licb_chan_path (
	input  wire clk,
	input  wire arst_n,
	input  wire tick,
	input  wire tx_pos,
	input  wire tx_neg,
	input  wire line_rx_pos,
	input  wire line_rx_neg,
	input  wire los,
	input  wire digital_loop,
	input  wire remote_loop,
	input  wire auto_all_ones,
	input  wire alarm_on_loss,
	output reg  rx_pos,
	output reg  rx_neg,
	output reg  line_tx_pos,
	output reg  line_tx_neg,
	output reg  ones_active
);

	reg enc_pos;
	reg enc_neg;
	reg mark;

	// ==========================================================
	// Encoder stage, alternating mark source, output muxes
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enc_pos     <= 1'b0;
			enc_neg     <= 1'b0;
			mark        <= 1'b0;
			rx_pos      <= 1'b0;
			rx_neg      <= 1'b0;
			line_tx_pos <= 1'b0;
			line_tx_neg <= 1'b0;
			ones_active <= 1'b0;
		end else begin
			enc_pos <= tx_pos;
			enc_neg <= tx_neg;
			if (tick) begin
				mark <= ~mark;
			end
			ones_active <= auto_all_ones & los;
			if (alarm_on_loss & los) begin
				rx_pos <= mark;
				rx_neg <= ~mark;
			end else if (digital_loop) begin
				rx_pos <= enc_pos;
				rx_neg <= enc_neg;
			end else begin
				rx_pos <= line_rx_pos;
				rx_neg <= line_rx_neg;
			end
			if (auto_all_ones & los) begin
				line_tx_pos <= mark;
				line_tx_neg <= ~mark;
			end else if (remote_loop) begin
				line_tx_pos <= line_rx_pos;
				line_tx_neg <= line_rx_neg;
			end else begin
				line_tx_pos <= enc_pos;
				line_tx_neg <= enc_neg;
			end
		end
	end

endmodule // licb_chan_path

// *** licb_top.v ***
// Notes on behaviour
// - Monitor code picks receive or transmit line
// - Digital loopback sends encoded transmit to receive
// - Attenuator position holds in loopback too
// - Both loopbacks set gives dual loopback
// - E1 criteria bit picks ETS or G.775
// - T1/J1 always uses T1.231 criteria
// - All-ones sent on loss when enabled
// - Global bit picks internal receive termination
// - External mode still trims per template except E1 120 ohm
// - Global alarm-on-loss overrides per channel
// - Global protection disable overrides per channel
// - Global AMI coding overrides per channel
// - Global depth bit forces 128 deep
// - Global position bit forces receive path
// - Global enable bit forces attenuator on
// - Pointer selects channel for template register
// - Pointer values map to channels ascending
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "licb_defines.vh"

module licb_top (
	input  wire        CLK,
	input  wire        ARST_N,
	input  wire [7:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output reg  [31:0] AVS_READDATA,
	output wire        AVS_WAITREQUEST,
	input  wire [7:0]  TRANSMIT_POSITIVE_DATA,
	input  wire [7:0]  TRANSMIT_NEGATIVE_DATA,
	output wire [7:0]  RECEIVE_POSITIVE_DATA,
	output wire [7:0]  RECEIVE_NEGATIVE_DATA,
	input  wire [7:0]  LINE_RX_POS,
	input  wire [7:0]  LINE_RX_NEG,
	output wire [7:0]  LINE_TX_POS,
	output wire [7:0]  LINE_TX_NEG,
	input  wire [7:0]  LOSS_OF_SIGNAL,
	input  wire [7:0]  TEMPLATE_E1,
	input  wire [7:0]  TEMPLATE_J1,
	input  wire [7:0]  TEMPLATE_120,
	input  wire [7:0]  RECEIVE_IMPEDANCE_OFF,
	output wire        MON_ENABLE,
	output wire        MON_TRANSMIT,
	output wire [7:0]  MON_LINE_SELECT,
	output reg  [7:0]  CRITERIA_ETS,
	output reg  [7:0]  CRITERIA_T1231,
	output reg  [7:0]  ALARM_ON_LOSS,
	output reg  [7:0]  PROTECTION_DISABLE,
	output reg  [7:0]  AMI_CODING,
	output reg  [7:0]  ATTEN_DEPTH_128,
	output reg  [7:0]  ATTEN_RX_PATH,
	output reg  [7:0]  ATTEN_ENABLE,
	output reg  [7:0]  DUAL_LOOPBACK,
	output reg         RX_TERM_INTERNAL,
	output reg  [23:0] RX_TRIM_CODE,
	output reg  [7:0]  TEMPLATE_CHANNEL_SELECT
);

	// ==========================================================
	// Helpers
	function [7:0] pick;
		input       global_bit;
		input [7:0] per_channel;
		begin
			pick = global_bit ? 8'hff : per_channel;
		end
	endfunction

	function [2:0] trim;
		input internal;
		input imp_off;
		input is_e1;
		input is_j1;
		input is_120;
		begin
			if (imp_off) begin
				trim = `LICB_TRIM_NONE;
			end else if (is_e1 && is_120) begin
				trim = internal ? `LICB_TRIM_120 : `LICB_TRIM_NONE;
			end else if (is_e1) begin
				trim = `LICB_TRIM_75;
			end else if (is_j1) begin
				trim = `LICB_TRIM_110;
			end else begin
				trim = `LICB_TRIM_100;
			end
		end
	endfunction

	function [7:0] chan_hot;
		input [2:0] ptr;
		begin
			chan_hot      = 8'h00;
			chan_hot[ptr] = 1'b1;
		end
	endfunction

	// ==========================================================
	// Declarations
	reg  [7:0] monitor_line_select;
	reg  [7:0] digital_loopback_bits;
	reg  [7:0] loss_alarm_criteria_bits;
	reg  [7:0] auto_all_ones_bits;
	reg  [7:0] global_configuration;
	reg  [7:0] template_channel_pointer;
	reg  [7:0] remote_loopback_bits;
	reg  [7:0] per_channel_alarm_on_loss;
	reg  [7:0] per_channel_protection_disable;
	reg  [7:0] per_channel_coding_select;
	reg  [7:0] per_channel_attenuator_depth;
	reg  [7:0] per_channel_attenuator_position;
	reg  [7:0] per_channel_attenuator_enable;
	reg  [7:0] los_meta;
	reg  [7:0] los_sync;
	reg  [7:0] rxp_meta;
	reg  [7:0] rxp_sync;
	reg  [7:0] rxn_meta;
	reg  [7:0] rxn_sync;
	reg        ack;
	reg  [`LICB_ONES_CNT_W-1:0] ones_cnt;
	reg        ones_tick;
	reg  [7:0] next_read;
	wire [7:0] ones_active;
	wire [7:0] alarm_eff;
	wire       request;
	wire       addr_ok;
	wire [5:0] index;
	wire       wr_ok;
	wire [7:0] wdata;
	integer    ch;

	// ==========================================================
	// Pin synchronisers
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			los_meta <= 8'h00;
			los_sync <= 8'h00;
			rxp_meta <= 8'h00;
			rxp_sync <= 8'h00;
			rxn_meta <= 8'h00;
			rxn_sync <= 8'h00;
		end else begin
			los_meta <= LOSS_OF_SIGNAL;
			los_sync <= los_meta;
			rxp_meta <= LINE_RX_POS;
			rxp_sync <= rxp_meta;
			rxn_meta <= LINE_RX_NEG;
			rxn_sync <= rxn_meta;
		end
	end

	// ==========================================================
	// All-ones timing from the master clock
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ones_cnt  <= {`LICB_ONES_CNT_W{1'b0}};
			ones_tick <= 1'b0;
		end else if (ones_cnt == (`LICB_ONES_CYCLES - 1)) begin
			ones_cnt  <= {`LICB_ONES_CNT_W{1'b0}};
			ones_tick <= 1'b1;
		end else begin
			ones_cnt  <= ones_cnt + 1'b1;
			ones_tick <= 1'b0;
		end
	end

	// ==========================================================
	// Avalon slave, one wait state per access
	assign request         = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = request & ~ack;
	assign index           = AVS_ADDRESS[7:2];
	assign addr_ok         = (AVS_ADDRESS[1:0] == 2'b00);
	assign wr_ok           = AVS_WRITE & ack & addr_ok & AVS_BYTEENABLE[0];
	assign wdata           = AVS_WRITEDATA[7:0];

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack <= 1'b0;
		end else begin
			ack <= request & ~ack;
		end
	end

	// ==========================================================
	// Register writes
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			monitor_line_select             <= `LICB_RESET_VALUE;
			digital_loopback_bits           <= `LICB_RESET_VALUE;
			loss_alarm_criteria_bits        <= `LICB_RESET_VALUE;
			auto_all_ones_bits              <= `LICB_RESET_VALUE;
			global_configuration            <= `LICB_RESET_VALUE;
			template_channel_pointer        <= `LICB_RESET_VALUE;
			remote_loopback_bits            <= `LICB_RESET_VALUE;
			per_channel_alarm_on_loss       <= `LICB_RESET_VALUE;
			per_channel_protection_disable  <= `LICB_RESET_VALUE;
			per_channel_coding_select       <= `LICB_RESET_VALUE;
			per_channel_attenuator_depth    <= `LICB_RESET_VALUE;
			per_channel_attenuator_position <= `LICB_RESET_VALUE;
			per_channel_attenuator_enable   <= `LICB_RESET_VALUE;
		end else if (wr_ok) begin
			case (index)
				`LICB_IDX_MONITOR: begin
					monitor_line_select <= wdata & `LICB_MONITOR_MASK;
				end
				`LICB_IDX_DIG_LOOP: begin
					digital_loopback_bits <= wdata;
				end
				`LICB_IDX_CRITERIA: begin
					loss_alarm_criteria_bits <= wdata;
				end
				`LICB_IDX_ALL_ONES: begin
					auto_all_ones_bits <= wdata;
				end
				`LICB_IDX_GLOBAL: begin
					global_configuration <= wdata & `LICB_GLOBAL_MASK;
				end
				`LICB_IDX_POINTER: begin
					template_channel_pointer <= wdata & `LICB_POINTER_MASK;
				end
				`LICB_IDX_REM_LOOP: begin
					remote_loopback_bits <= wdata;
				end
				`LICB_IDX_CH_ALARM: begin
					per_channel_alarm_on_loss <= wdata;
				end
				`LICB_IDX_CH_PROT: begin
					per_channel_protection_disable <= wdata;
				end
				`LICB_IDX_CH_CODING: begin
					per_channel_coding_select <= wdata;
				end
				`LICB_IDX_CH_DEPTH: begin
					per_channel_attenuator_depth <= wdata;
				end
				`LICB_IDX_CH_POS: begin
					per_channel_attenuator_position <= wdata;
				end
				`LICB_IDX_CH_ENABLE: begin
					per_channel_attenuator_enable <= wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux, unmapped reads return zero
	always @* begin
		next_read = 8'h00;
		if (addr_ok) begin
			case (index)
				`LICB_IDX_MONITOR:   next_read = monitor_line_select;
				`LICB_IDX_DIG_LOOP:  next_read = digital_loopback_bits;
				`LICB_IDX_CRITERIA:  next_read = loss_alarm_criteria_bits;
				`LICB_IDX_ALL_ONES:  next_read = auto_all_ones_bits;
				`LICB_IDX_GLOBAL:    next_read = global_configuration;
				`LICB_IDX_POINTER:   next_read = template_channel_pointer;
				`LICB_IDX_REM_LOOP:  next_read = remote_loopback_bits;
				`LICB_IDX_CH_ALARM:  next_read = per_channel_alarm_on_loss;
				`LICB_IDX_CH_PROT:   next_read = per_channel_protection_disable;
				`LICB_IDX_CH_CODING: next_read = per_channel_coding_select;
				`LICB_IDX_CH_DEPTH:  next_read = per_channel_attenuator_depth;
				`LICB_IDX_CH_POS:    next_read = per_channel_attenuator_position;
				`LICB_IDX_CH_ENABLE: next_read = per_channel_attenuator_enable;
				`LICB_IDX_STATUS:    next_read = ones_active;
				default:             next_read = 8'h00;
			endcase
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			AVS_READDATA <= 32'h00000000;
		end else if (AVS_READ & ~ack) begin
			AVS_READDATA <= {24'h000000, next_read};
		end
	end

	// ==========================================================
	// Effective per-channel settings
	assign alarm_eff = pick(global_configuration[`LICB_GLB_ALARM_ON_LOSS],
		per_channel_alarm_on_loss);

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CRITERIA_ETS            <= 8'h00;
			CRITERIA_T1231          <= 8'h00;
			ALARM_ON_LOSS           <= 8'h00;
			PROTECTION_DISABLE      <= 8'h00;
			AMI_CODING              <= 8'h00;
			ATTEN_DEPTH_128         <= 8'h00;
			ATTEN_RX_PATH           <= 8'h00;
			ATTEN_ENABLE            <= 8'h00;
			DUAL_LOOPBACK           <= 8'h00;
			RX_TERM_INTERNAL        <= 1'b0;
			RX_TRIM_CODE            <= 24'h000000;
			TEMPLATE_CHANNEL_SELECT <= 8'h00;
		end else begin
			CRITERIA_ETS   <= TEMPLATE_E1 & loss_alarm_criteria_bits;
			CRITERIA_T1231 <= ~TEMPLATE_E1;
			ALARM_ON_LOSS  <= alarm_eff;
			PROTECTION_DISABLE <= pick(global_configuration[`LICB_GLB_PROT_DISABLE],
				per_channel_protection_disable);
			AMI_CODING <= pick(global_configuration[`LICB_GLB_AMI],
				per_channel_coding_select);
			ATTEN_DEPTH_128 <= pick(global_configuration[`LICB_GLB_DEPTH_128],
				per_channel_attenuator_depth);
			ATTEN_RX_PATH <= pick(global_configuration[`LICB_GLB_POSITION_RX],
				per_channel_attenuator_position);
			ATTEN_ENABLE <= pick(global_configuration[`LICB_GLB_ATTEN_ENABLE],
				per_channel_attenuator_enable);
			DUAL_LOOPBACK    <= digital_loopback_bits & remote_loopback_bits;
			RX_TERM_INTERNAL <= global_configuration[`LICB_GLB_RX_INTERNAL];
			for (ch = 0; ch < 8; ch = ch + 1) begin
				RX_TRIM_CODE[3*ch +: 3] <= trim(
					global_configuration[`LICB_GLB_RX_INTERNAL],
					RECEIVE_IMPEDANCE_OFF[ch], TEMPLATE_E1[ch],
					TEMPLATE_J1[ch], TEMPLATE_120[ch]);
			end
			TEMPLATE_CHANNEL_SELECT <= chan_hot(template_channel_pointer[2:0]);
		end
	end

	// ==========================================================
	// Monitor selection
	licb_mon_decode u_mon (
		.clk          (CLK),
		.arst_n       (ARST_N),
		.select       (monitor_line_select[3:0]),
		.mon_enable   (MON_ENABLE),
		.mon_transmit (MON_TRANSMIT),
		.mon_line     (MON_LINE_SELECT)
	);

	// ==========================================================
	// Channel data paths
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gen_chan
			licb_chan_path u_path (
				.clk           (CLK),
				.arst_n        (ARST_N),
				.tick          (ones_tick),
				.tx_pos        (TRANSMIT_POSITIVE_DATA[g]),
				.tx_neg        (TRANSMIT_NEGATIVE_DATA[g]),
				.line_rx_pos   (rxp_sync[g]),
				.line_rx_neg   (rxn_sync[g]),
				.los           (los_sync[g]),
				.digital_loop  (digital_loopback_bits[g]),
				.remote_loop   (remote_loopback_bits[g]),
				.auto_all_ones (auto_all_ones_bits[g]),
				.alarm_on_loss (alarm_eff[g]),
				.rx_pos        (RECEIVE_POSITIVE_DATA[g]),
				.rx_neg        (RECEIVE_NEGATIVE_DATA[g]),
				.line_tx_pos   (LINE_TX_POS[g]),
				.line_tx_neg   (LINE_TX_NEG[g]),
				.ones_active   (ones_active[g])
			);
		end
	endgenerate

endmodule // licb_top

// *** licb_props.sv ***
`timescale 1ns/1ns
// ==========================================================
// Bus and configuration checks
module licb_props (
	input wire        CLK,
	input wire        ARST_N,
	input wire [7:0]  AVS_ADDRESS,
	input wire        AVS_READ,
	input wire        AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0]  AVS_BYTEENABLE,
	input wire [31:0] AVS_READDATA,
	input wire        AVS_WAITREQUEST,
	input wire [7:0]  TEMPLATE_E1,
	input wire [7:0]  RECEIVE_IMPEDANCE_OFF,
	input wire        MON_ENABLE,
	input wire        MON_TRANSMIT,
	input wire [7:0]  MON_LINE_SELECT,
	input wire [7:0]  CRITERIA_ETS,
	input wire [7:0]  CRITERIA_T1231,
	input wire [7:0]  AMI_CODING,
	input wire        RX_TERM_INTERNAL,
	input wire [23:0] RX_TRIM_CODE,
	input wire [7:0]  TEMPLATE_CHANNEL_SELECT
);
	default clocking dcb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	logic wr_done;
	assign wr_done = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	chk_one_wait:
		assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request not answered after one wait state");
	chk_bad_addr:
		assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0
			|-> AVS_READDATA == 32'h0) else $error("misaligned read not zero");
	chk_mon_line:
		assert property (wr_done && AVS_ADDRESS == 8'h2c |=> ##1 MON_LINE_SELECT ==
			((8'h01 << $past(AVS_WRITEDATA[2:0], 2)) & 8'hfe)) else $error("monitor line wrong");
	chk_mon_dir:
		assert property (wr_done && AVS_ADDRESS == 8'h2c |=> ##1
			MON_ENABLE == ($past(AVS_WRITEDATA[2:0], 2) != 3'h0) &&
			MON_TRANSMIT == ($past(AVS_WRITEDATA[3], 2) && MON_ENABLE))
		else $error("monitor enable or direction wrong");
	chk_ptr_select:
		assert property (wr_done && AVS_ADDRESS == 8'h40 |=> ##1 TEMPLATE_CHANNEL_SELECT ==
			8'h01 << $past(AVS_WRITEDATA[2:0], 2)) else $error("pointer channel wrong");
	chk_global_term:
		assert property (wr_done && AVS_ADDRESS == 8'h3c |=> ##1
			RX_TERM_INTERNAL == $past(AVS_WRITEDATA[7], 2)) else $error("termination mode wrong");
	chk_global_ami:
		assert property (wr_done && AVS_ADDRESS == 8'h3c && AVS_WRITEDATA[4] |=> ##1
			AMI_CODING == 8'hff) else $error("global coding not applied");
	chk_t1_criteria:
		assert property ($past(ARST_N) |-> CRITERIA_T1231 == ~$past(TEMPLATE_E1))
		else $error("T1 criteria wrong");
	chk_ets_e1:
		assert property ($past(ARST_N) |-> (CRITERIA_ETS & ~$past(TEMPLATE_E1)) == 8'h00)
		else $error("ETS criteria outside E1");
	chk_imp_off:
		assert property ($past(ARST_N) && $past(RECEIVE_IMPEDANCE_OFF[4])
			|-> RX_TRIM_CODE[14:12] == 3'h0) else $error("trim active with impedance off");
endmodule // licb_props

bind licb_top licb_props u_props (.CLK(CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .TEMPLATE_E1(TEMPLATE_E1),
	.RECEIVE_IMPEDANCE_OFF(RECEIVE_IMPEDANCE_OFF), .MON_ENABLE(MON_ENABLE),
	.MON_TRANSMIT(MON_TRANSMIT), .MON_LINE_SELECT(MON_LINE_SELECT),
	.CRITERIA_ETS(CRITERIA_ETS), .CRITERIA_T1231(CRITERIA_T1231), .AMI_CODING(AMI_CODING),
	.RX_TERM_INTERNAL(RX_TERM_INTERNAL), .RX_TRIM_CODE(RX_TRIM_CODE),
	.TEMPLATE_CHANNEL_SELECT(TEMPLATE_CHANNEL_SELECT));

// *** licb_host.sv ***
`timescale 1ns/1ns
// ==========================================================
// Host processor on the register bus
module licb_host (
	input  wire         clk,
	output logic [7:0]  avs_address,
	output logic        avs_read,
	output logic        avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0]  avs_byteenable,
	input  wire  [31:0] avs_readdata,
	input  wire         avs_waitrequest
);
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	// Request held until the edge that sees waitrequest low
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
endmodule // licb_host

// *** testbench.sv ***
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench
module testbench;
	logic        clk, arst_n;
	logic [7:0]  tx_p, tx_n, lrx_p, lrx_n, los, t_e1, t_j1, t_120, imp_off;
	wire  [7:0]  adr, rx_p, rx_n, ltx_p, ltx_n, mon_line, ets, t1231, aol, prot, ami;
	wire  [7:0]  depth, rxpath, att_en, dual, tsel;
	wire  [31:0] wdat, rdat;
	wire  [3:0]  be;
	wire  [23:0] trim;
	wire         rd_s, wr_s, wait_r, mon_en, mon_tx, term;
	int          err_count, checks, cyc;
	logic [31:0] q;
	licb_host host (.clk(clk), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
		.avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_r));
	licb_top DUT (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
		.AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wait_r), .TRANSMIT_POSITIVE_DATA(tx_p), .TRANSMIT_NEGATIVE_DATA(tx_n),
		.RECEIVE_POSITIVE_DATA(rx_p), .RECEIVE_NEGATIVE_DATA(rx_n), .LINE_RX_POS(lrx_p),
		.LINE_RX_NEG(lrx_n), .LINE_TX_POS(ltx_p), .LINE_TX_NEG(ltx_n), .LOSS_OF_SIGNAL(los),
		.TEMPLATE_E1(t_e1), .TEMPLATE_J1(t_j1), .TEMPLATE_120(t_120),
		.RECEIVE_IMPEDANCE_OFF(imp_off), .MON_ENABLE(mon_en), .MON_TRANSMIT(mon_tx),
		.MON_LINE_SELECT(mon_line), .CRITERIA_ETS(ets), .CRITERIA_T1231(t1231),
		.ALARM_ON_LOSS(aol), .PROTECTION_DISABLE(prot), .AMI_CODING(ami),
		.ATTEN_DEPTH_128(depth), .ATTEN_RX_PATH(rxpath), .ATTEN_ENABLE(att_en),
		.DUAL_LOOPBACK(dual), .RX_TERM_INTERNAL(term), .RX_TRIM_CODE(trim),
		.TEMPLATE_CHANNEL_SELECT(tsel));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 8'h00, q);
		check(q, e);
	endtask
	function automatic logic [7:0] pick(input int k);
		case (k)
			0: return aol;
			1: return prot;
			2: return ami;
			3: return depth;
			4: return rxpath;
			default: return att_en;
		endcase
	endfunction
	// ==========================================================
	// Scenarios
	task t_regs;
		logic [7:0] mk [5];
		int i;
		mk = '{8'hff, 8'hff, 8'hff, 8'hfb, 8'h07};
		for (i = 0; i < 5; i++) begin
			rd(8'h30 + 8'(i * 4), 32'h0);
			wr(8'h30 + 8'(i * 4), 8'hff);
			rd(8'h30 + 8'(i * 4), {24'h0, mk[i]});
			wr(8'h30 + 8'(i * 4), 8'h00);
		end
		rd(8'h31, 32'h0);
		rd(8'hfc, 32'h0);
		$display("Test registers done");
	endtask
	task t_mon;
		int i;
		for (i = 0; i < 16; i++) begin
			wr(8'h2c, 8'(i));
			@(negedge clk);
			check(mon_line, (8'h01 << i[2:0]) & 8'hfe);
			check(mon_en, i[2:0] != 3'h0);
			check(mon_tx, i[3] && i[2:0] != 3'h0);
			@(posedge clk);
		end
		$display("Test monitor done");
	endtask
	task t_ptr;
		int i;
		for (i = 0; i < 8; i++) begin
			wr(8'h40, 8'hf8 | 8'(i));
			@(negedge clk);
			check(tsel, 8'h01 << i);
			@(posedge clk);
			rd(8'h40, 32'(i));
		end
		$display("Test pointer done");
	endtask
	task t_glob;
		logic [7:0] gb [6];
		int k;
		gb = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
		for (k = 0; k < 6; k++) begin
			wr(8'h60 + 8'(k * 4), 8'h5a);
			@(negedge clk);
			check(pick(k), 8'h5a);
			@(posedge clk);
			wr(8'h3c, gb[k]);
			@(negedge clk);
			check(pick(k), 8'hff);
			@(posedge clk);
			wr(8'h3c, 8'h00);
			wr(8'h60 + 8'(k * 4), 8'h00);
		end
		$display("Test global overrides done");
	endtask
	task t_trim;
		t_e1 <= 8'h1c;
		t_j1 <= 8'h02;
		t_120 <= 8'h08;
		imp_off <= 8'h10;
		wr(8'h34, 8'h0f);
		@(negedge clk);
		check(ets, 8'h0c);
		check(t1231, 8'he3);
		check(trim, 24'h49005a);
		check(term, 1'b0);
		@(posedge clk);
		wr(8'h3c, 8'h80);
		@(negedge clk);
		check(trim, 24'h49085a);
		check(term, 1'b1);
		@(posedge clk);
		wr(8'h3c, 8'h00);
		$display("Test criteria and trim done");
	endtask
	task t_loop;
		logic [1:0] h [0:15];
		int i;
		wr(8'h3c, 8'h12);
		wr(8'h5c, 8'h01);
		@(negedge clk);
		check(dual, 8'h00);
		@(posedge clk);
		wr(8'h30, 8'h01);
		@(negedge clk);
		check(dual, 8'h01);
		check(rxpath, 8'hff);
		@(posedge clk);
		for (i = 0; i < 16; i++) begin
			h[i] = {i % 4 == 1, i % 4 == 3};
			tx_p <= {7'h00, h[i][1]};
			tx_n <= {7'h00, h[i][0]};
			lrx_p <= {7'h00, h[i][1]};
			lrx_n <= {7'h00, h[i][0]};
			@(negedge clk);
			if (i >= 2)
				check({rx_p[0], rx_n[0]}, h[i - 2]);
			if (i >= 3)
				check({ltx_p[0], ltx_n[0]}, h[i - 3]);
			@(posedge clk);
		end
		tx_p <= 8'h00;
		tx_n <= 8'h00;
		lrx_p <= 8'h00;
		lrx_n <= 8'h00;
		wr(8'h30, 8'h00);
		wr(8'h5c, 8'h00);
		wr(8'h3c, 8'h00);
		$display("Test loopback done");
	endtask
	task t_ones;
		int i, n, t, z;
		logic p;
		n = 0;
		t = 0;
		z = 0;
		wr(8'h38, 8'h01);
		wr(8'h60, 8'h02);
		los <= 8'h03;
		repeat (4) @(posedge clk);
		rd(8'h78, 32'h1);
		@(negedge clk);
		p = ltx_p[0];
		for (i = 0; i < 60; i++) begin
			@(negedge clk);
			n += (ltx_p[0] !== ltx_n[0]);
			t += (ltx_p[0] !== p);
			z += (ltx_p[1] !== 1'b0 || ltx_n[1] !== 1'b0);
			p = ltx_p[0];
		end
		check(n, 60);
		check(t >= 2 && t <= 3, 1'b1);
		check(z, 0);
		check({rx_p[1] ^ rx_n[1], rx_p[0] | rx_n[0]}, 2'b10);
		@(posedge clk);
		los <= 8'h00;
		repeat (4) @(posedge clk);
		rd(8'h78, 32'h0);
		wr(8'h38, 8'h00);
		wr(8'h60, 8'h00);
		$display("Test all ones done");
	endtask
	// ==========================================================
	// Clock, watchdog and sequence
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc > 20000) begin
				err_count++;
				tally_and_finish;
			end
		end
	end
	initial begin
		err_count = 0;
		checks = 0;
		arst_n = 1'b0;
		{tx_p, tx_n, lrx_p, lrx_n, los} = 40'h0;
		{t_e1, t_j1, t_120, imp_off} = 32'h0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_mon;
		t_ptr;
		t_glob;
		t_trim;
		t_loop;
		t_ones;
		tally_and_finish;
	end
endmodule // testbench
